/* rtl/pec_pkg.sv */
// constants, states and carriers of the extended control two register block
// assumes one 250 MHz system clock and a serial management port on pins
`default_nettype none
package pec_pkg;
  // clock rate used to turn times into cycle counts
  localparam int CLK_MHZ = 250;
  // register location on the serial management port
  localparam logic [4:0] REG_ADDR = 5'h13;
  // frame opcodes and field sizes
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  // bit positions inside the register
  localparam int BIT_NODE_REP = 15;
  localparam int BIT_SW_MODE = 14;
  localparam int BIT_REM_FAULT = 13;
  localparam int BIT_RO_RSVD = 10;
  localparam int BIT_FLOAT = 7;
  localparam int BIT_AUTO_PD = 0;
  // low 13 bits held in flops; bit 10 reads zero and ignores writes
  localparam logic [12:0] CTL_RESET = 13'h0001;
  localparam logic [12:0] CTL_WR_MASK = 13'h1bff;
  // strap sampling point after reset release, past the two sync flops
  localparam logic [1:0] CAP_AT = 2'h2;
  localparam logic [1:0] CAP_DONE = 2'h3;
  // heartbeat timing after transmit enable falls
  localparam int HB_DELAY_NS = 1000;
  localparam int HB_WIDTH_NS = 1000;
  localparam int HB_DELAY_CYC = (HB_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int HB_WIDTH_CYC = (HB_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [9:0] HB_DELAY_LAST = 10'(HB_DELAY_CYC - 1);
  localparam logic [9:0] HB_WIDTH_LAST = 10'(HB_WIDTH_CYC - 1);

  typedef enum logic [1:0] {
    MD_PRE = 2'b00,
    MD_HDR = 2'b01,
    MD_TA = 2'b10,
    MD_DATA = 2'b11
  } pec_mdio_e;

  typedef enum logic [1:0] {
    HB_IDLE = 2'b00,
    HB_WAIT = 2'b01,
    HB_PULSE = 2'b10
  } pec_hb_e;

  // status from the rest of the transceiver, same clock
  typedef struct packed {
    logic speed_100;
    logic link_up;
    logic full_duplex;
    logic tx_en;
    logic rx_active;
    logic collision;
    logic remote_fault;
    logic isolate;
    logic heartbeat_inhibit;
  } pec_link_s;
endpackage : pec_pkg
`default_nettype wire

/* rtl/pec_mfpin.sv */
// multifunction pins: management address strap, then status indicators
// assumes capture pulses once per hardware reset, on the same clock
`default_nettype none
module pec_mfpin (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic capture,
  input wire logic [4:0] pin_in,
  input wire logic [4:0] led_on,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe_n,
  output logic [4:0] addr
);
  import pec_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_pin
      logic meta_reg;
      logic sync_reg;
      logic samp_reg;
      logic samp_next;
      logic oe_n_reg;
      logic oe_n_next;
      logic out_reg;
      logic out_next;

      always_comb begin
        samp_next = capture ? sync_reg : samp_reg;
        oe_n_next = capture ? 1'b0 : oe_n_reg;
        // lit level is the opposite of the strapped level
        out_next = oe_n_reg ? 1'b0 : (led_on[i] ^ samp_reg);
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          samp_reg <= 1'b0;
          oe_n_reg <= 1'b1;
          out_reg <= 1'b0;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
          samp_reg <= samp_next;
          oe_n_reg <= oe_n_next;
          out_reg <= out_next;
        end
      end

      assign pin_out[i] = out_reg;
      assign pin_oe_n[i] = oe_n_reg;
      assign addr[i] = samp_reg;
    end
  endgenerate
endmodule : pec_mfpin
`default_nettype wire

/* rtl/pec_ext_ctl2.sv */
// extended control two register with its serial management slave,
// strap capture, carrier sense, heartbeat and power-down control
// assumes mdc/mdio and straps arrive asynchronously; link status is on clk_sys
`default_nettype none
module pec_ext_ctl2 (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sw_reset,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic node_repeater_strap,
  input wire logic software_config_mode,
  input wire pec_pkg::pec_link_s link,
  input wire logic [4:0] mfpin_in,
  output logic [4:0] mfpin_out,
  output logic [4:0] mfpin_oe_n,
  output logic [4:0] management_address,
  output logic crs,
  output logic col,
  output logic heartbeat_test,
  output logic config_from_regs,
  output logic pair_output_float_enable,
  output logic tx100_power_down,
  output logic speed_100
);
  import pec_pkg::*;

  // pin synchronisers; first stages feed only the second stages
  logic mdc_meta_reg;
  logic mdc_sync_reg;
  logic mdc_last_reg;
  logic mdio_meta_reg;
  logic mdio_sync_reg;
  logic nr_meta_reg;
  logic nr_sync_reg;
  logic sw_meta_reg;
  logic sw_sync_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mdc_meta_reg <= 1'b0;
      mdc_sync_reg <= 1'b0;
      mdc_last_reg <= 1'b0;
      mdio_meta_reg <= 1'b1;
      mdio_sync_reg <= 1'b1;
      nr_meta_reg <= 1'b0;
      nr_sync_reg <= 1'b0;
      sw_meta_reg <= 1'b0;
      sw_sync_reg <= 1'b0;
    end else begin
      mdc_meta_reg <= mdc;
      mdc_sync_reg <= mdc_meta_reg;
      mdc_last_reg <= mdc_sync_reg;
      mdio_meta_reg <= mdio_in;
      mdio_sync_reg <= mdio_meta_reg;
      nr_meta_reg <= node_repeater_strap;
      nr_sync_reg <= nr_meta_reg;
      sw_meta_reg <= software_config_mode;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  logic mdc_rise;
  assign mdc_rise = mdc_sync_reg & ~mdc_last_reg;

  // strap capture once after reset release; software reset leaves it alone
  logic [1:0] cap_cnt_reg;
  logic [1:0] cap_cnt_next;
  logic capture;
  logic node_rep_reg;
  logic node_rep_next;
  logic sw_mode_reg;
  logic sw_mode_next;

  assign capture = (cap_cnt_reg == CAP_AT);

  always_comb begin
    cap_cnt_next = cap_cnt_reg + 2'(cap_cnt_reg != CAP_DONE);
    node_rep_next = capture ? nr_sync_reg : node_rep_reg;
    sw_mode_next = capture ? sw_sync_reg : sw_mode_reg;
  end

  // everything here is held in reset while arst_n is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cap_cnt_reg <= 2'h0;
      node_rep_reg <= 1'b0;
      sw_mode_reg <= 1'b0;
    end else begin
      cap_cnt_reg <= cap_cnt_next;
      node_rep_reg <= node_rep_next;
      sw_mode_reg <= sw_mode_next;
    end
  end

  // management frame slave; only preambles of at least 32 ones are accepted
  pec_mdio_e md_state_reg;
  pec_mdio_e md_state_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [12:0] hdr_reg;
  logic [12:0] hdr_next;
  logic [15:0] sh_reg;
  logic [15:0] sh_next;
  logic is_read_reg;
  logic is_read_next;
  logic hit_reg;
  logic hit_next;
  logic md_out_reg;
  logic md_out_next;
  logic md_oe_n_reg;
  logic md_oe_n_next;
  logic [12:0] ctl_reg;
  logic [12:0] ctl_next;
  logic [15:0] rd_value;
  logic [15:0] wr_value;

  // bit 13 is live so it always matches the partner ability copy
  always_comb begin
    rd_value = {node_rep_reg, sw_mode_reg, link.remote_fault, ctl_reg};
    rd_value[BIT_REM_FAULT] = link.remote_fault;
    rd_value[BIT_RO_RSVD] = 1'b0;
  end

  assign wr_value = {sh_reg[14:0], mdio_sync_reg};

  always_comb begin
    md_state_next = md_state_reg;
    cnt_next = cnt_reg;
    hdr_next = hdr_reg;
    sh_next = sh_reg;
    is_read_next = is_read_reg;
    hit_next = hit_reg;
    md_out_next = md_out_reg;
    md_oe_n_next = md_oe_n_reg;
    ctl_next = ctl_reg;
    if (mdc_rise) begin
      case (md_state_reg)
        MD_PRE: begin
          if (mdio_sync_reg) begin
            cnt_next = (cnt_reg == PRE_ONES) ? cnt_reg : cnt_reg + 6'h1;
          end else if (cnt_reg == PRE_ONES) begin
            md_state_next = MD_HDR;
            cnt_next = 6'h0;
          end else begin
            cnt_next = 6'h0;
          end
        end
        MD_HDR: begin
          hdr_next = {hdr_reg[11:0], mdio_sync_reg};
          cnt_next = cnt_reg + 6'h1;
          if (cnt_reg == HDR_LAST) begin
            cnt_next = 6'h0;
            // other registers of this address are passed over silently
            hit_next = (hdr_next[9:5] == management_address) &&
                       (hdr_next[4:0] == REG_ADDR);
            is_read_next = (hdr_next[11:10] == OP_READ);
            if (hdr_next[12] && (hdr_next[11:10] == OP_READ ||
                                 hdr_next[11:10] == OP_WRITE)) begin
              md_state_next = MD_TA;
            end else begin
              md_state_next = MD_PRE;
            end
          end
        end
        MD_TA: begin
          cnt_next = cnt_reg + 6'h1;
          if (cnt_reg == 6'h0) begin
            if (is_read_reg && hit_reg) begin
              md_oe_n_next = 1'b0;
              md_out_next = 1'b0;
            end
          end else begin
            md_state_next = MD_DATA;
            cnt_next = 6'h0;
            sh_next = rd_value;
            md_out_next = rd_value[15];
          end
        end
        MD_DATA: begin
          cnt_next = cnt_reg + 6'h1;
          sh_next = wr_value;
          md_out_next = sh_reg[14];
          if (cnt_reg == DATA_LAST) begin
            md_state_next = MD_PRE;
            cnt_next = 6'h0;
            md_oe_n_next = 1'b1;
            md_out_next = 1'b0;
            if (!is_read_reg && hit_reg) begin
              // reserved bits other than bit 10 keep what was written; they steer nothing
              ctl_next = (ctl_reg & ~CTL_WR_MASK) |
                         (wr_value[12:0] & CTL_WR_MASK);
            end
          end
        end
        default: begin
          md_state_next = MD_PRE;
          cnt_next = 6'h0;
          md_oe_n_next = 1'b1;
        end
      endcase
    end
    if (sw_reset) begin
      ctl_next = CTL_RESET;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      md_state_reg <= MD_PRE;
      cnt_reg <= 6'h0;
      hdr_reg <= 13'h0000;
      sh_reg <= 16'h0000;
      is_read_reg <= 1'b0;
      hit_reg <= 1'b0;
      md_out_reg <= 1'b0;
      md_oe_n_reg <= 1'b1;
      ctl_reg <= CTL_RESET;
    end else begin
      md_state_reg <= md_state_next;
      cnt_reg <= cnt_next;
      hdr_reg <= hdr_next;
      sh_reg <= sh_next;
      is_read_reg <= is_read_next;
      hit_reg <= hit_next;
      md_out_reg <= md_out_next;
      md_oe_n_reg <= md_oe_n_next;
      ctl_reg <= ctl_next;
    end
  end

  assign mdio_out = md_out_reg;
  assign mdio_oe_n = md_oe_n_reg;

  // heartbeat: collision pulse a fixed time after transmit enable falls
  pec_hb_e hb_state_reg;
  pec_hb_e hb_state_next;
  logic [9:0] hb_cnt_reg;
  logic [9:0] hb_cnt_next;
  logic tx_en_last_reg;
  logic hb_en;

  // full duplex and repeater use suppress it whatever the inhibit says
  assign hb_en = !node_rep_reg && !link.heartbeat_inhibit &&
                 !link.full_duplex;

  always_comb begin
    hb_state_next = hb_state_reg;
    hb_cnt_next = hb_cnt_reg;
    case (hb_state_reg)
      HB_IDLE: begin
        if (tx_en_last_reg && !link.tx_en && hb_en) begin
          hb_state_next = HB_WAIT;
          hb_cnt_next = 10'h000;
        end
      end
      HB_WAIT: begin
        hb_cnt_next = hb_cnt_reg + 10'h001;
        if (hb_cnt_reg == HB_DELAY_LAST) begin
          hb_state_next = HB_PULSE;
          hb_cnt_next = 10'h000;
        end
      end
      HB_PULSE: begin
        hb_cnt_next = hb_cnt_reg + 10'h001;
        if (hb_cnt_reg == HB_WIDTH_LAST) begin
          hb_state_next = HB_IDLE;
          hb_cnt_next = 10'h000;
        end
      end
      default: begin
        hb_state_next = HB_IDLE;
        hb_cnt_next = 10'h000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hb_state_reg <= HB_IDLE;
      hb_cnt_reg <= 10'h000;
      tx_en_last_reg <= 1'b0;
    end else begin
      hb_state_reg <= hb_state_next;
      hb_cnt_reg <= hb_cnt_next;
      tx_en_last_reg <= link.tx_en;
    end
  end

  // registered status and control outputs
  logic crs_reg;
  logic col_reg;
  logic hb_test_reg;
  logic cfg_regs_reg;
  logic float_reg;
  logic pd100_reg;
  logic speed_reg;
  logic [4:0] led_on;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
      hb_test_reg <= 1'b0;
      cfg_regs_reg <= 1'b0;
      float_reg <= 1'b0;
      pd100_reg <= 1'b0;
      speed_reg <= 1'b0;
    end else begin
      crs_reg <= node_rep_reg ? link.rx_active
                              : (link.tx_en | link.rx_active);
      col_reg <= link.collision | (hb_state_reg == HB_PULSE);
      hb_test_reg <= hb_en;
      cfg_regs_reg <= sw_mode_reg;
      float_reg <= ctl_reg[BIT_FLOAT];
      pd100_reg <= (ctl_reg[BIT_AUTO_PD] && !link.speed_100) ||
                   link.isolate;
      speed_reg <= link.speed_100;
    end
  end

  assign crs = crs_reg;
  assign col = col_reg;
  assign heartbeat_test = hb_test_reg;
  assign config_from_regs = cfg_regs_reg;
  assign pair_output_float_enable = float_reg;
  assign tx100_power_down = pd100_reg;
  assign speed_100 = speed_reg;

  // indicator order: rx, tx, link, collision, activity
  assign led_on = {link.rx_active, link.tx_en, link.link_up, link.collision,
                   link.tx_en | link.rx_active};

  pec_mfpin u_mfpin (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .capture(capture),
    .pin_in(mfpin_in),
    .led_on(led_on),
    .pin_out(mfpin_out),
    .pin_oe_n(mfpin_oe_n),
    .addr(management_address)
  );
endmodule : pec_ext_ctl2
`default_nettype wire

/* test/pec_ext_ctl2_sva.sv */
// assertions on the extended control two block ports
// assumes one clock domain and an asynchronous active-low reset
`default_nettype none
module pec_chk
  import pec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic node_repeater_strap,
  input wire pec_pkg::pec_link_s link,
  input wire logic [4:0] mfpin_oe_n,
  input wire logic [4:0] management_address,
  input wire logic mdio_oe_n,
  input wire logic crs,
  input wire logic col,
  input wire logic heartbeat_test,
  input wire logic tx100_power_down,
  input wire logic speed_100
);
  timeunit 1ns;
  timeprecision 1ps;
  // design delay plus state and output register stages, slack for pin timing
  localparam int HB_LO = 248;
  localparam int HB_HI = 256;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  a_speed_pin_high: assert property (link.speed_100 |=> speed_100)
    else $error("speed pin low at 100");
  a_isolate_power_down: assert property
    (link.isolate |=> tx100_power_down)
    else $error("isolate left 100 powered");
  a_fast_powered_on: assert property
    (link.speed_100 && !link.isolate |=> !tx100_power_down)
    else $error("100 powered down while at 100");
  a_node_carrier: assert property
    (!node_repeater_strap && (link.tx_en || link.rx_active) |=> crs)
    else $error("carrier missing in node mode");
  a_collision_passes: assert property (link.collision |=> col)
    else $error("collision not passed");
  a_heartbeat_pulse: assert property
    ($fell(link.tx_en) && heartbeat_test |-> ##[HB_LO:HB_HI] col)
    else $error("heartbeat pulse missing");
  a_strap_hold: assert property
    ($rose(arst_n) |-> mfpin_oe_n == 5'h1f && mdio_oe_n)
    else $error("pins driven during strap sampling");
  a_pins_drive: assert property
    ($rose(arst_n) |-> ##4 mfpin_oe_n == 5'h00)
    else $error("indicator pins not driven");
  a_address_held: assert property
    (mfpin_oe_n == 5'h00 |=> $stable(management_address))
    else $error("address changed after capture");
  c_heartbeat: cover property ($rose(col) && !link.collision);
  c_read_drive: cover property ($fell(mdio_oe_n));
  c_carrier: cover property ($rose(crs));
endmodule : pec_chk
bind pec_ext_ctl2 pec_chk u_pec_chk (
  .clk_sys, .arst_n, .node_repeater_strap, .link, .mfpin_oe_n,
  .management_address, .mdio_oe_n, .crs, .col, .heartbeat_test,
  .tx100_power_down, .speed_100
);
`default_nettype wire

/* test/pec_sta_model.sv */
// station manager model: management frames on the clock and data pins
// assumes a pull-up on the data pin, so a released line reads one
`default_nettype none
module pec_sta_model
  import pec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output logic mdc = 1'b0,
  output logic mdio_in,
  output logic [15:0] rd_data = '0,
  output logic rd_valid = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic bit_q = 1'b1;
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv ? bit_q : 1'b1);
  // mdc stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, input int half);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd & 16'he081};
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk_sys);
      drv <= (op == OP_WRITE) || i > 17;
      bit_q <= f[i];
      mdc <= 1'b0;
      repeat (half) @(posedge clk_sys);
      if (i < 16) rd_data[i] <= mdio_in;
      mdc <= 1'b1;
      repeat (half - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    drv <= 1'b0;
    mdc <= 1'b0;
    rd_valid <= (op == OP_READ);
    @(posedge clk_sys);
    rd_valid <= 1'b0;
  endtask : frame
endmodule : pec_sta_model
`default_nettype wire

/* test/pec_ext_ctl2_test.sv */
// self-checking bench for the extended control two block
// assumes the station model and the bound checker are compiled
`default_nettype none
module pec_ext_ctl2_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pec_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic sw_reset = 1'b0;
  logic node_repeater_strap = 1'b0;
  logic software_config_mode = 1'b1;
  pec_link_s link = pec_link_s'(9'h001);
  logic [4:0] my_addr = 5'h00;
  logic mdc, mdio_in, mdio_out, mdio_oe_n, crs, col, heartbeat_test;
  logic config_from_regs, pair_output_float_enable, tx100_power_down;
  logic speed_100, rd_valid;
  logic [4:0] mfpin_in, mfpin_out, mfpin_oe_n, management_address;
  logic [15:0] rd_data;
  logic [15:0] exp_q[$];
  logic [12:0] ctl = 13'h0001;
  int err_total = 0;
  int samples_checked = 0;
  int half = 4;
  int n;
  int w;
  // pin level: strap resistor unless the device drives
  assign mfpin_in = (mfpin_out & ~mfpin_oe_n) | (my_addr & mfpin_oe_n);
  always #2 clk_sys = ~clk_sys;
  pec_ext_ctl2 u_pec_ext_ctl2 (.clk_sys, .arst_n, .sw_reset, .mdc,
    .mdio_in, .mdio_out, .mdio_oe_n, .node_repeater_strap,
    .software_config_mode, .link, .mfpin_in, .mfpin_out, .mfpin_oe_n,
    .management_address, .crs, .col, .heartbeat_test, .config_from_regs,
    .pair_output_float_enable, .tx100_power_down, .speed_100);
  pec_sta_model u_pec_sta_model (.clk_sys, .mdio_out, .mdio_oe_n, .mdc,
    .mdio_in, .rd_data, .rd_valid);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  always @(posedge clk_sys) begin
    if (rd_valid) check(rd_data, exp_q.pop_front());
  end
  function automatic logic [15:0] exp_val();
    return {node_repeater_strap, software_config_mode, link.remote_fault, ctl};
  endfunction : exp_val
  // alternate prompt and slow management clock
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] d, input logic [15:0] e);
    if (op == OP_READ) exp_q.push_back(e);
    half = (half == 4) ? 9 : 4;
    u_pec_sta_model.frame(op, pa, ra, d, half);
    repeat (4) @(posedge clk_sys);
  endtask : xfer
  task automatic do_reset(input logic nr, input logic sw);
    arst_n <= 1'b0;
    node_repeater_strap <= nr;
    software_config_mode <= sw;
    my_addr <= 5'($urandom);
    repeat (8) @(posedge clk_sys);
    check(16'(mfpin_oe_n), 16'h001f);
    check(16'(mdio_oe_n), 16'h0001);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(16'(management_address), 16'(my_addr));
    check(16'(config_from_regs), 16'(sw));
    ctl = 13'h0001;
  endtask : do_reset
  task automatic status_loop();
    pec_link_s l;
    logic [4:0] led;
    logic exp_crs;
    logic exp_pd;
    for (int i = 0; i < 6; i++) begin
      l = pec_link_s'(9'($urandom) | 9'h001);
      link <= l;
      repeat (4) @(posedge clk_sys);
      led = {l.rx_active, l.tx_en, l.link_up, l.collision,
             l.tx_en | l.rx_active};
      // repeater use senses receive only
      exp_crs = l.rx_active | (l.tx_en & ~node_repeater_strap);
      exp_pd = (ctl[0] & ~l.speed_100) | l.isolate;
      check(16'(crs), 16'(exp_crs));
      check(16'(col), 16'(l.collision));
      check(16'(speed_100), 16'(l.speed_100));
      check(16'(tx100_power_down), 16'(exp_pd));
      check(16'(mfpin_out), 16'(led ^ my_addr));
    end
  endtask : status_loop
  initial begin
    void'($urandom(32'hab33ccac));
    do_reset(1'b0, 1'b1);
    link <= pec_link_s'(9'h005);
    @(posedge clk_sys);
    xfer(OP_READ, my_addr, REG_ADDR, 16'h0, exp_val());
    xfer(OP_WRITE, my_addr, REG_ADDR, 16'he080, 16'h0);
    ctl = 13'h0080;
    check(16'(pair_output_float_enable), 16'h0001);
    xfer(OP_READ, my_addr, REG_ADDR, 16'h0, exp_val());
    status_loop();
    // refused frames leave the line to its pull-up
    xfer(OP_READ, my_addr ^ 5'h01, REG_ADDR, 16'h0, 16'hffff);
    xfer(OP_READ, my_addr, 5'h12, 16'h0, 16'hffff);
    sw_reset <= 1'b1;
    @(posedge clk_sys);
    sw_reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ctl = 13'h0001;
    check(16'(pair_output_float_enable), 16'h0000);
    check(16'(management_address), 16'(my_addr));
    xfer(OP_READ, my_addr, REG_ADDR, 16'h0, exp_val());
    status_loop();
    // quiet transmit under inhibit first, else a late fall starts a pulse
    link <= pec_link_s'(9'h001);
    repeat (4) @(posedge clk_sys);
    link <= pec_link_s'(9'h000);
    repeat (4) @(posedge clk_sys);
    check(16'(heartbeat_test), 16'h0001);
    link.tx_en <= 1'b1;
    repeat (20) @(posedge clk_sys);
    link.tx_en <= 1'b0;
    n = 0;
    w = 0;
    while (col !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    while (col === 1'b1 && w < 400) begin
      @(negedge clk_sys);
      w++;
    end
    check(16'(n >= 248 && n <= 258), 16'h1);
    check(16'(w), 16'(HB_WIDTH_CYC));
    do_reset(1'b1, 1'b0);
    check(16'(heartbeat_test), 16'h0000);
    xfer(OP_READ, my_addr, REG_ADDR, 16'h0, exp_val());
    status_loop();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    final_report();
  end
endmodule : pec_ext_ctl2_test
`default_nettype wire
